// ===== include/vrt_defs.vh
// timing constants for the interlaced raster timing generator
`ifndef VRT_DEFS_VH
`define VRT_DEFS_VH

// core clock rate, Hz
`define VRT_CORE_CLK_HZ          32'd40000000

// 625-line standard
`define VRT_625_PIXEL_HZ         32'd14700000
`define VRT_625_LINE_TOTAL       10'd944
`define VRT_625_LINE_START       10'd152
`define VRT_625_LINE_ACTIVE      10'd768
`define VRT_625_FRAME_TOTAL      10'd625
`define VRT_625_FIELD_START      10'd53
`define VRT_625_FRAME_ACTIVE     10'd572
`define VRT_625_FIELD0_LINES     10'd313

// 525-line standard
`define VRT_525_PIXEL_HZ         32'd12272725
`define VRT_525_LINE_TOTAL       10'd780
`define VRT_525_LINE_START       10'd118
`define VRT_525_LINE_ACTIVE      10'd640
`define VRT_525_FRAME_TOTAL      10'd525
`define VRT_525_FIELD_START      10'd17
`define VRT_525_FRAME_ACTIVE     10'd508
`define VRT_525_FIELD0_LINES     10'd263

// strap settling cycles after reset release
`define VRT_STRAP_SETTLE         2'd3

`endif

// ===== rtl/vrt_raster_timing.v
// interlaced raster timing generator for the 625-line and 525-line standards
`include "vrt_defs.vh"

// Functional notes
// - 625-line: 944-pixel line, active 152 for 768
// - 625-line: 14.7 MHz pixels, 625 lines, start 53
// - 525-line: 12.272725 MHz, 780 total, 118 start, 640
// - 525-line: 525 lines interlaced, start line 17
// - 525-line active lines equal 525 minus 17; here 491 per frame, as each field starts at field line 17
// - standard fixed by strap, never switched live
module vrt_raster_timing #(
  // core clock rate in Hz; the pixel divider works from it
  parameter [31:0] CORE_CLK_HZ = `VRT_CORE_CLK_HZ
) (
  input  wire       core_clk_in,
  input  wire       resetn_in,
  input  wire       std_525_strap_in,
  output reg        ready_out,
  output reg        std_525_out,
  output reg        pixel_en_out,
  output reg  [9:0] pixel_count_out,
  output reg  [9:0] line_count_out,
  output reg  [9:0] field_line_out,
  output reg        field_out,
  output reg        line_start_out,
  output reg        frame_start_out,
  output reg        active_out
);

  // ----------------------------------------------------------------
  // strap capture
  // ----------------------------------------------------------------
  // the strap is sampled once after reset and then frozen, so a
  // glitch on the pin later cannot change the raster mid-frame;
  // the pin is not on this clock, so it passes two flops first,
  // and a board that changes the strap needs a reset to apply it
  reg       strap_s1;
  reg       strap_s2;
  reg [1:0] settle;

  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      strap_s1    <= 1'b0;
      strap_s2    <= 1'b0;
      settle      <= 2'h0;
      ready_out   <= 1'b0;
      std_525_out <= 1'b0;
    end else begin
      strap_s1 <= std_525_strap_in;
      strap_s2 <= strap_s1;
      if (!ready_out) begin
        if (settle == `VRT_STRAP_SETTLE) begin
          ready_out   <= 1'b1;
          std_525_out <= strap_s2;
        end else begin
          settle <= settle + 2'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // per-standard constants
  // ----------------------------------------------------------------
  // one selector for every count pair keeps the two tables aligned
  function [9:0] pick;
    input       sel_525;
    input [9:0] val_525;
    input [9:0] val_625;
    begin
      pick = sel_525 ? val_525 : val_625;
    end
  endfunction

  wire [31:0] pixel_hz     = std_525_out ? `VRT_525_PIXEL_HZ : `VRT_625_PIXEL_HZ;
  wire [9:0]  line_total   = pick(std_525_out, `VRT_525_LINE_TOTAL, `VRT_625_LINE_TOTAL);
  wire [9:0]  line_start   = pick(std_525_out, `VRT_525_LINE_START, `VRT_625_LINE_START);
  wire [9:0]  line_active  = pick(std_525_out, `VRT_525_LINE_ACTIVE, `VRT_625_LINE_ACTIVE);
  wire [9:0]  frame_total  = pick(std_525_out, `VRT_525_FRAME_TOTAL, `VRT_625_FRAME_TOTAL);
  wire [9:0]  field_start  = pick(std_525_out, `VRT_525_FIELD_START, `VRT_625_FIELD_START);
  wire [9:0]  frame_active = pick(std_525_out, `VRT_525_FRAME_ACTIVE, `VRT_625_FRAME_ACTIVE);
  wire [9:0]  field0_lines = pick(std_525_out, `VRT_525_FIELD0_LINES, `VRT_625_FIELD0_LINES);

  // ----------------------------------------------------------------
  // fractional pixel-rate divider
  // ----------------------------------------------------------------
  // phase accumulator in Hz: average rate is exact, jitter is one
  // core clock, which is the price of running on a single clock
  reg  [31:0] phase;
  wire [31:0] phase_sum = phase + pixel_hz;
  // the pixel tick is the only enable; every raster counter moves on it
  wire        tick      = ready_out && (phase_sum >= CORE_CLK_HZ);

  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      phase <= 32'h0;
    end else if (ready_out) begin
      phase <= tick ? (phase_sum - CORE_CLK_HZ) : phase_sum;
    end
  end

  // ----------------------------------------------------------------
  // raster counters
  // ----------------------------------------------------------------
  reg [9:0] active_lines;
  reg [9:0] next_pixel;
  reg [9:0] next_line;
  reg [9:0] next_field_line;
  reg       next_field;
  reg [9:0] next_active_lines;
  reg       next_line_start;
  reg       next_frame_start;
  reg       next_active;

  // the same last-value test serves pixels, lines and the first
  // field, so it is one function rather than three comparators
  function at_last;
    input [9:0] count;
    input [9:0] total;
    begin
      at_last = (count == total - 10'h1);
    end
  endfunction

  // the window is half open: first is inside, first plus span is not
  function in_window;
    input [9:0] pos;
    input [9:0] first;
    input [9:0] span;
    begin
      in_window = (pos >= first) && (pos < first + span);
    end
  endfunction

  wire line_end    = tick && at_last(pixel_count_out, line_total);
  wire frame_end   = line_end && at_last(line_count_out, frame_total);
  wire field0_end  = line_end && !field_out && at_last(field_line_out, field0_lines);
  // a finished line counts against the frame budget only once its
  // field has passed the vertical start
  wire line_counts = line_end && (field_line_out >= field_start) && (active_lines < frame_active);

  // ----------------------------------------------------------------
  // counter steps
  // ----------------------------------------------------------------
  // horizontal: step on every pixel tick, wrap at the line total
  always @* begin
    next_pixel      = pixel_count_out;
    next_line_start = 1'b0;
    if (line_end) begin
      next_pixel      = 10'h0;
      next_line_start = 1'b1;
    end else if (tick) begin
      next_pixel = pixel_count_out + 10'h1;
    end
  end

  // vertical: the first field is the longer one, so the second
  // field always ends together with the frame
  always @* begin
    next_line         = line_count_out;
    next_field_line   = field_line_out;
    next_field        = field_out;
    next_active_lines = active_lines;
    next_frame_start  = 1'b0;
    if (line_counts) begin
      next_active_lines = active_lines + 10'h1;
    end
    if (frame_end) begin
      next_line         = 10'h0;
      next_field_line   = 10'h0;
      next_field        = 1'b0;
      next_active_lines = 10'h0;
      next_frame_start  = 1'b1;
    end else if (field0_end) begin
      next_line       = line_count_out + 10'h1;
      next_field_line = 10'h0;
      next_field      = 1'b1;
    end else if (line_end) begin
      next_line       = line_count_out + 10'h1;
      next_field_line = field_line_out + 10'h1;
    end
  end

  // active needs both windows and the per-frame line budget; it is
  // taken from the next counts so it lines up with the shown counters
  wire h_window = in_window(next_pixel, line_start, line_active);
  wire v_window = (next_field_line >= field_start) && (next_active_lines < frame_active);

  always @* begin
    next_active = ready_out && h_window && v_window;
  end

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  // every output leaves a flop so a peripheral sees clean edges
  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pixel_count_out <= 10'h0;
      line_count_out  <= 10'h0;
      field_line_out  <= 10'h0;
      field_out       <= 1'b0;
      active_lines    <= 10'h0;
      pixel_en_out    <= 1'b0;
      line_start_out  <= 1'b0;
      frame_start_out <= 1'b0;
      active_out      <= 1'b0;
    end else begin
      pixel_count_out <= next_pixel;
      line_count_out  <= next_line;
      field_line_out  <= next_field_line;
      field_out       <= next_field;
      active_lines    <= next_active_lines;
      pixel_en_out    <= tick;
      line_start_out  <= next_line_start;
      frame_start_out <= next_frame_start;
      active_out      <= next_active;
    end
  end

endmodule

// ===== verification/vrt_raster_assertions.sv
// concurrent checks on the raster timing generator outputs
module vrt_raster_checker (
  input logic       core_clk_in,
  input logic       resetn_in,
  input logic       ready_out,
  input logic       std_525_out,
  input logic       pixel_en_out,
  input logic       field_out,
  input logic       line_start_out,
  input logic       frame_start_out,
  input logic       active_out,
  input logic [9:0] pixel_count_out,
  input logic [9:0] line_count_out,
  input logic [9:0] field_line_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  wire [9:0] lt = std_525_out ? 10'd780 : 10'd944;
  wire [9:0] ls = std_525_out ? 10'd118 : 10'd152;
  wire [9:0] la = std_525_out ? 10'd640 : 10'd768;
  a_pixel_bound: assert property (ready_out |-> pixel_count_out < lt) else $error("pixel past total");
  a_line_bound: assert property (ready_out |-> line_count_out < (std_525_out ? 10'd525 : 10'd625))
    else $error("line past total");
  a_std_frozen: assert property (ready_out |=> $stable(std_525_out) && ready_out) else $error("std moved");
  a_active_horiz: assert property (active_out |-> pixel_count_out >= ls && pixel_count_out < ls + la)
    else $error("active outside line window");
  a_active_vert: assert property (active_out |-> field_line_out >= (std_525_out ? 10'd17 : 10'd53))
    else $error("active before field start");
  a_wrap_zero: assert property (line_start_out |-> pixel_en_out && pixel_count_out == 10'h0)
    else $error("line start not at zero");
  a_frame_zero: assert property (frame_start_out |-> line_start_out && line_count_out == 10'h0)
    else $error("frame start not at line zero");
  a_pixel_gap: assert property (pixel_en_out |=> !pixel_en_out) else $error("pixel steps too close");
  a_count_holds: assert property (ready_out && $past(ready_out) && !pixel_en_out |-> $stable(pixel_count_out))
    else $error("pixel moved without step");
  a_pixel_spacing: assert property (pixel_en_out |-> ##[2:4] pixel_en_out)
    else $error("pixel steps too far apart");
  a_field_split: assert property (ready_out |->
    line_count_out == field_line_out + (field_out ? (std_525_out ? 10'd263 : 10'd313) : 10'd0))
    else $error("field line count off frame line");
endmodule

// ===== verification/vrt_video_sink.sv
// recorder model that latches the last pixel index of each line
module vrt_video_sink (
  input  wire logic       core_clk_in,
  input  wire logic       pixel_en_in,
  input  wire logic [9:0] pixel_count_in,
  output logic      [9:0] last_pixel_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] prev;
  // a recorder locks onto the count seen just before each line restart
  always @(posedge core_clk_in) begin
    if (pixel_en_in) prev <= pixel_count_in;
    if (pixel_en_in && pixel_count_in == 10'h0) last_pixel_out <= prev;
  end
endmodule

// ===== verification/tb_vrt_raster_timing.sv
// self-checking bench for the raster timing generator
module tb_vrt_raster_timing;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_in = 0, resetn_in = 0, std_525_strap_in = 0;
  wire  ready_out, std_525_out, pixel_en_out, field_out, line_start_out, frame_start_out, active_out;
  wire  [9:0] pixel_count_out, line_count_out, field_line_out, last_pixel;
  logic [31:0] seed = 32'd39970;
  logic [9:0] prev;
  int miscompares = 0, cmp_count = 0, pulses, cyc, act;
  bit abort = 0;
  vrt_raster_timing i_vrt_raster_timing (.core_clk_in, .resetn_in, .std_525_strap_in, .ready_out,
    .std_525_out, .pixel_en_out, .pixel_count_out, .line_count_out, .field_line_out, .field_out,
    .line_start_out, .frame_start_out, .active_out);
  vrt_video_sink i_vrt_video_sink (.core_clk_in, .pixel_en_in(pixel_en_out), .pixel_count_in(pixel_count_out),
    .last_pixel_out(last_pixel));
  initial forever #12.5 core_clk_in = ~core_clk_in;
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function logic [9:0] tot(input logic s);
    return s ? 10'd780 : 10'd944;
  endfunction
  // active pixel steps over lines 0..nl-1: whole active lines times span
  function int act_exp(input logic s, input int nl);
    int start;
    start = s ? 17 : 53;
    return (nl > start) ? (nl - start) * (s ? 640 : 768) : 0;
  endfunction
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %0d seen %0d", n, e, s);
    end
  endtask
  task conclude();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // strap wiggles after capture must change nothing
  task run(input logic s, input int nl);
    int n, k;
    resetn_in = 0;
    std_525_strap_in = s;
    repeat (8) @(negedge core_clk_in);
    resetn_in = 1;
    for (n = 0; n < 10 && ready_out !== 1'b1; n++) @(negedge core_clk_in);
    chk("ready", 1, ready_out);
    chk("std", s, std_525_out);
    act = 0;
    for (k = 0; k < nl; k++) begin
      for (n = 0; n < 4000; n++) begin
        @(negedge core_clk_in);
        std_525_strap_in = (xs() & 32'h1) != 32'h0;
        pulses += pixel_en_out;
        cyc++;
        act += pixel_en_out && active_out;
        if (line_start_out === 1'b1) break;
      end
      if (n == 4000) begin
        miscompares++;
        abort = 1;
        return;
      end
      if (k > 0) chk("line", prev + 10'd1, line_count_out);
      if (k > 0) chk("field line", prev + 10'd1, field_line_out);
      chk("field", 0, field_out);
      chk("frame start", 0, frame_start_out);
      chk("pixel at start", 0, pixel_count_out);
      if (k == 1) {pulses, cyc} = 0;
      prev = line_count_out;
    end
    chk("last pixel", tot(s) - 10'd1, last_pixel);
    chk("pixels", (nl - 2) * tot(s), pulses);
    chk("rate", 1, (cyc - (nl - 2) * tot(s) * (s ? 3.2593 : 2.7211)) ** 2 < 16);
    chk("active", act_exp(s, nl), act);
    chk("std held", s, std_525_out);
  endtask
  initial begin
    run(0, 4);
    if (!abort) run(1, 20);
    conclude();
  end
endmodule
bind vrt_raster_timing vrt_raster_checker i_vrt_raster_checker (.core_clk_in, .resetn_in, .ready_out,
  .std_525_out, .pixel_en_out, .line_start_out, .frame_start_out, .active_out, .pixel_count_out,
  .line_count_out, .field_line_out, .field_out);
